/* pin_cfg_pkg.sv */
package pin_cfg_pkg;

	// register offsets inside the configuration region
	localparam logic [11:0] TCLK_CFG_OFS     = 12'hC26;
	localparam logic [11:0] PAD_DRV_OFS      = 12'hC28;
	localparam logic [11:0] GPIO_LO_DIR_OFS  = 12'hC2A;
	localparam logic [11:0] GPIO_HI_DIR_OFS  = 12'hC2C;
	localparam logic [11:0] NEXT_HALF_STEP   = 12'h002;

	// timer_clock_pin_config fields
	localparam int          PIN_ENABLE_BIT   = 0;
	localparam int          PIN_DIR_BIT      = 1;
	localparam int          SRC_LSB          = 4;
	localparam int          SRC_MSB          = 6;
	localparam logic [7:0]  TCLK_CFG_RST     = 8'h70;
	localparam logic [7:0]  TCLK_CFG_MASK    = 8'h73;

	// test_clock_source codes
	localparam logic [2:0]  SRC_RTC          = 3'h0;
	localparam logic [2:0]  SRC_SERIAL_SLOW  = 3'h1;
	localparam logic [2:0]  SRC_SERIAL_FAST  = 3'h2;
	localparam logic [2:0]  SRC_TIMER        = 3'h3;
	localparam logic [2:0]  SRC_SYNTH1       = 3'h4;
	localparam logic [2:0]  SRC_SYNTH2       = 3'h5;
	localparam logic [2:0]  SRC_OFF_A        = 3'h6;
	localparam logic [2:0]  SRC_OFF_B        = 3'h7;
	localparam int          NUM_SRC          = 6;

	// pad_drive_strength fields
	localparam int          CS_DRV_LSB       = 8;
	localparam int          CMD_DRV_LSB      = 6;
	localparam int          MASK_DRV_LSB     = 4;
	localparam int          ADDR_DRV_LSB     = 2;
	localparam int          DATA_DRV_LSB     = 0;
	localparam int          DRV_W            = 2;
	localparam logic [15:0] PAD_DRV_RST      = 16'h0200;
	localparam logic [15:0] PAD_DRV_MASK     = 16'h03FF;

	// gpio_low_direction
	localparam int          GPIO_W           = 16;
	localparam logic [15:0] GPIO_DIR_RST     = 16'h0000;

	// access sizes on the configuration port
	localparam logic [1:0]  SZ_BYTE          = 2'h0;
	localparam logic [1:0]  SZ_WORD          = 2'h1;
	localparam logic [1:0]  SZ_DWORD         = 2'h2;

	localparam int          SYNC_STAGES      = 3;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_UPPER = 2'b10
	} access_phase_t;

endpackage

/* pin_sync3.sv */
`timescale 1ns/1ps
module pin_sync3 import pin_cfg_pkg::*; #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_b_in,
	// asynchronous levels and their filtered copies
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic [SYNC_STAGES-1:0] stg_r;
			logic [SYNC_STAGES-1:0] stg_nxt;
			logic                   filt_r;
			logic                   filt_nxt;

			// a change is taken only once stages two and three agree
			always_comb
			begin
				stg_nxt  = {stg_r[SYNC_STAGES-2:0], async_in[i]};
				filt_nxt = (stg_r[1] == stg_r[2]) ? stg_r[2] : filt_r;
			end

			always_ff @(posedge clk_sys_in or negedge rst_b_in)
			begin
				if (!rst_b_in)
				begin
					stg_r  <= '0;
					filt_r <= 1'b0;
				end
				else
				begin
					stg_r  <= stg_nxt;
					filt_r <= filt_nxt;
				end
			end

			assign level_out[i] = filt_r;
		end
	endgenerate

endmodule // pin_sync3

/* test_clock_select.sv */
`timescale 1ns/1ps
module test_clock_select import pin_cfg_pkg::*; (
	// selector and candidate clocks
	input  wire logic [2:0]         source_in,
	input  wire logic [NUM_SRC-1:0] clocks_in,
	// chosen clock, low when disabled
	output logic                    clock_out
);

	always_comb
	begin
		unique case (source_in)
			SRC_RTC:         clock_out = clocks_in[0];
			SRC_SERIAL_SLOW: clock_out = clocks_in[1];
			SRC_SERIAL_FAST: clock_out = clocks_in[2];
			SRC_TIMER:       clock_out = clocks_in[3];
			SRC_SYNTH1:      clock_out = clocks_in[4];
			SRC_SYNTH2:      clock_out = clocks_in[5];
			SRC_OFF_A:       clock_out = 1'b0;
			SRC_OFF_B:       clock_out = 1'b0;
		endcase
	end

endmodule // test_clock_select

/* pin_config_clock_test_pad_drive.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1 - With the pin driven as an output it carries the clock picked by the 3-bit test_clock_source code 000 to 101.
// RULE2 - Source codes 110 and 111 turn the test clock off and hold the pin low.
// RULE3 - Direction bit 1 makes the pin a timer clock input when 0 and a test clock output when 1.
// RULE4 - Enable bit 0 resets to 0 and the pin does nothing, in or out, until software sets it.
// RULE5 - An enabled clock input is synchronised to the system clock before it reaches the interval timer.
// RULE6 - There is no glitch suppression, so anything fed by the pin is kept in reset while it is set up; the code filters until two sync stages agree.
// RULE7 - Software writes zero to every reserved bit of the clock and drive registers.
// RULE8 - Chip-select pad strength in bits 9:8 is 01 for 18 mA and 10 for 12 mA, resets to 10, others reserved.
// RULE9 - Other pad strength fields give 00 for 24 mA (reset), 01 for 18 mA, 10 for 12 mA, 11 reserved.
// RULE10 - Command pads use bits 7:6, byte masks 5:4, address and bank 3:2, data and check bits 1:0.
// RULE11 - The pad strength register keeps its value through a software programmable reset.
// RULE12 - The low direction register holds one bit per I/O pin, 0 for input and 1 for output.
// RULE13 - All sixteen direction bits are read/write and reset to 0.
// RULE14 - After reset every I/O pin is an undriven input until its direction bit is set.
// RULE15 - A direction bit is ignored while the pin's function select bit is set.
// RULE16 - A 32-bit access at the low direction offset runs as two 16-bit accesses, low register first.
// RULE17 - The clock config register resets with source 111 and direction and enable at 0.
module pin_config_clock_test_pad_drive import pin_cfg_pkg::*; (
	// clock and resets
	input  wire logic              clk_sys_in,
	input  wire logic              rst_b_in,
	input  wire logic              soft_reset_in,
	// configuration region access port
	input  wire logic              req_in,
	input  wire logic              wr_in,
	input  wire logic [1:0]        size_in,
	input  wire logic [11:0]       addr_in,
	input  wire logic [31:0]       wdata_in,
	output logic                   ack_out,
	output logic      [31:0]       rdata_out,
	output logic                   busy_out,
	// upper direction register, held outside
	output logic                   hi_dir_wr_out,
	output logic      [15:0]       hi_dir_wdata_out,
	input  wire logic [15:0]       hi_dir_rdata_in,
	// internal clocks offered to the test pin
	input  wire logic              rtc_clock_in,
	input  wire logic              serial_slow_clock_in,
	input  wire logic              serial_fast_clock_in,
	input  wire logic              interval_timer_clock_in,
	input  wire logic              first_synth_clock_in,
	input  wire logic              second_synth_clock_in,
	// timer clock / test clock pin
	input  wire logic              external_timer_clock_in,
	output logic                   test_clock_out,
	output logic                   test_clock_oe_out,
	// to the interval timer
	output logic                   timer_pin_clock_sel_out,
	output logic                   timer_pin_clock_out,
	output logic                   timer_pin_tick_out,
	// pad strength controls
	output logic      [DRV_W-1:0]  chip_select_pad_strength_out,
	output logic      [DRV_W-1:0]  command_pad_strength_out,
	output logic      [DRV_W-1:0]  byte_mask_pad_strength_out,
	output logic      [DRV_W-1:0]  address_pad_strength_out,
	output logic      [DRV_W-1:0]  data_pad_strength_out,
	// low general-purpose pins
	input  wire logic [GPIO_W-1:0] gpio_function_select_bit_in,
	output logic      [GPIO_W-1:0] gpio_direction_bit_out,
	output logic      [GPIO_W-1:0] gpio_oe_out
);

	access_phase_t     state_r;
	access_phase_t     state_nxt;
	logic [11:0]       addr_r;
	logic [11:0]       addr_nxt;
	logic              wr_r;
	logic              wr_nxt;
	logic [15:0]       whi_r;
	logic [15:0]       whi_nxt;
	logic [15:0]       rdlo_r;
	logic [15:0]       rdlo_nxt;
	logic              ack_r;
	logic              ack_nxt;
	logic [31:0]       rdata_r;
	logic [31:0]       rdata_nxt;
	logic              busy_r;
	logic              busy_nxt;
	logic              hi_wr_r;
	logic              hi_wr_nxt;
	logic [15:0]       hi_wdata_r;
	logic [15:0]       hi_wdata_nxt;

	logic [7:0]        tclk_cfg_r;
	logic [7:0]        tclk_cfg_nxt;
	logic [15:0]       pad_drv_r;
	logic [15:0]       pad_drv_nxt;
	logic [15:0]       gpio_dir_r;
	logic [15:0]       gpio_dir_nxt;
	logic [15:0]       gpio_oe_r;
	logic [15:0]       gpio_oe_nxt;

	logic              test_clk_r;
	logic              test_clk_nxt;
	logic              test_oe_r;
	logic              test_oe_nxt;
	logic              tmr_sel_r;
	logic              tmr_sel_nxt;
	logic              tmr_clk_r;
	logic              tmr_clk_nxt;
	logic              tmr_tick_r;
	logic              tmr_tick_nxt;

	// access decode terms
	logic [11:0]       cur_addr;
	logic [11:0]       word_addr;
	logic [15:0]       cur_data;
	logic [15:0]       wr_word;
	logic [1:0]        cur_size;
	logic              active;
	logic              do_write;
	logic              odd_byte;
	logic              lane_lo;
	logic              lane_hi;
	logic [15:0]       lane_mask;
	logic [15:0]       rd_word;
	logic [15:0]       rd_sel;

	logic              pin_enable;
	logic              pin_is_out;
	logic              sel_clock;
	logic              pin_level;
	logic [NUM_SRC-1:0] src_clocks_async;
	logic [NUM_SRC-1:0] src_clocks;

	assign src_clocks_async = {second_synth_clock_in, first_synth_clock_in, interval_timer_clock_in,
		serial_fast_clock_in, serial_slow_clock_in, rtc_clock_in};

	// candidate clocks come from other domains
	pin_sync3 #(
		.WIDTH      (NUM_SRC)
	) u_src_sync (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.async_in   (src_clocks_async),
		.level_out  (src_clocks)
	);

	pin_sync3 #(
		.WIDTH      (1)
	) u_pin_sync (
		.clk_sys_in (clk_sys_in),
		.rst_b_in   (rst_b_in),
		.async_in   (external_timer_clock_in),
		.level_out  (pin_level)                                  // [RULE5]
	);

	test_clock_select u_mux (
		.source_in  (tclk_cfg_r[SRC_MSB:SRC_LSB]),
		.clocks_in  (src_clocks),
		.clock_out  (sel_clock)                                  // [RULE1] [RULE2]
	);

	// register access, second phase handles the upper half of a 32-bit access
	always_comb
	begin
		cur_addr  = (state_r == ST_UPPER) ? addr_r + NEXT_HALF_STEP : addr_in;       // [RULE16]
		cur_data  = (state_r == ST_UPPER) ? whi_r : wdata_in[15:0];
		cur_size  = (state_r == ST_UPPER) ? SZ_WORD : size_in;
		word_addr = {cur_addr[11:1], 1'b0};
		active    = (state_r == ST_UPPER) || req_in;
		do_write  = active && ((state_r == ST_UPPER) ? wr_r : wr_in);
		odd_byte  = (cur_size == SZ_BYTE) && cur_addr[0];
		lane_lo   = !odd_byte;
		lane_hi   = (cur_size != SZ_BYTE) || cur_addr[0];
		lane_mask = {{8{lane_hi}}, {8{lane_lo}}};
		wr_word   = odd_byte ? {cur_data[7:0], 8'h00} : cur_data;

		tclk_cfg_nxt = tclk_cfg_r;
		pad_drv_nxt  = pad_drv_r;
		gpio_dir_nxt = gpio_dir_r;
		hi_wr_nxt    = 1'b0;
		hi_wdata_nxt = hi_wdata_r;
		rd_word      = 16'h0000;

		unique case (word_addr)
			TCLK_CFG_OFS:
			begin
				rd_word = {8'h00, tclk_cfg_r};
				if (do_write && lane_lo)
					tclk_cfg_nxt = wr_word[7:0] & TCLK_CFG_MASK;   // [RULE7]
			end
			PAD_DRV_OFS:
			begin
				rd_word = pad_drv_r;
				if (do_write)
					pad_drv_nxt = ((pad_drv_r & ~lane_mask) | (wr_word & lane_mask)) & PAD_DRV_MASK; // [RULE8] [RULE9]
			end
			GPIO_LO_DIR_OFS:
			begin
				rd_word = gpio_dir_r;
				if (do_write)
					gpio_dir_nxt = (gpio_dir_r & ~lane_mask) | (wr_word & lane_mask);  // [RULE12] [RULE13]
			end
			GPIO_HI_DIR_OFS:
			begin
				rd_word = hi_dir_rdata_in;
				if (do_write)
				begin
					hi_wr_nxt    = 1'b1;                               // [RULE16]
					hi_wdata_nxt = wr_word;
				end
			end
			default:
				rd_word = 16'h0000;
		endcase

		// programmable reset spares the pad strength register
		if (soft_reset_in)
		begin
			tclk_cfg_nxt = TCLK_CFG_RST;                              // [RULE17]
			gpio_dir_nxt = GPIO_DIR_RST;                              // [RULE11] [RULE14]
		end

		if (odd_byte)
			rd_sel = {8'h00, rd_word[15:8]};
		else if (cur_size == SZ_BYTE)
			rd_sel = {8'h00, rd_word[7:0]};
		else
			rd_sel = rd_word;

		state_nxt = ST_IDLE;
		addr_nxt  = addr_r;
		wr_nxt    = wr_r;
		whi_nxt   = whi_r;
		rdlo_nxt  = rdlo_r;
		ack_nxt   = 1'b0;
		rdata_nxt = rdata_r;
		unique case (state_r)
			ST_IDLE:
			begin
				if (req_in && (size_in == SZ_DWORD))
				begin
					state_nxt = ST_UPPER;                              // [RULE16]
					addr_nxt  = addr_in;
					wr_nxt    = wr_in;
					whi_nxt   = wdata_in[31:16];
					rdlo_nxt  = rd_sel;
				end
				else if (req_in)
				begin
					ack_nxt   = 1'b1;
					rdata_nxt = {16'h0000, rd_sel};
				end
			end
			ST_UPPER:
			begin
				ack_nxt   = 1'b1;
				rdata_nxt = {rd_sel, rdlo_r};
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		busy_nxt = (state_nxt == ST_UPPER);
	end

	// pin and pad behaviour from the stored configuration
	always_comb
	begin
		pin_enable   = tclk_cfg_r[PIN_ENABLE_BIT];                   // [RULE4]
		pin_is_out   = tclk_cfg_r[PIN_DIR_BIT];                      // [RULE3]
		test_oe_nxt  = pin_enable && pin_is_out;
		test_clk_nxt = test_oe_nxt ? sel_clock : 1'b0;              // [RULE1] [RULE2]
		tmr_sel_nxt  = pin_enable && !pin_is_out;                    // [RULE3]
		tmr_clk_nxt  = tmr_sel_nxt ? pin_level : 1'b0;              // [RULE5]
		tmr_tick_nxt = tmr_clk_nxt && !tmr_clk_r;
		gpio_oe_nxt  = gpio_dir_r & ~gpio_function_select_bit_in;   // [RULE14] [RULE15]
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state_r    <= ST_IDLE;
			addr_r     <= 12'h000;
			wr_r       <= 1'b0;
			whi_r      <= 16'h0000;
			rdlo_r     <= 16'h0000;
			ack_r      <= 1'b0;
			rdata_r    <= 32'h0000_0000;
			busy_r     <= 1'b0;
			hi_wr_r    <= 1'b0;
			hi_wdata_r <= 16'h0000;
			tclk_cfg_r <= TCLK_CFG_RST;                              // [RULE4] [RULE17]
			pad_drv_r  <= PAD_DRV_RST;                               // [RULE8] [RULE9]
			gpio_dir_r <= GPIO_DIR_RST;                              // [RULE13]
			gpio_oe_r  <= 16'h0000;
			test_clk_r <= 1'b0;
			test_oe_r  <= 1'b0;
			tmr_sel_r  <= 1'b0;
			tmr_clk_r  <= 1'b0;
			tmr_tick_r <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			addr_r     <= addr_nxt;
			wr_r       <= wr_nxt;
			whi_r      <= whi_nxt;
			rdlo_r     <= rdlo_nxt;
			ack_r      <= ack_nxt;
			rdata_r    <= rdata_nxt;
			busy_r     <= busy_nxt;
			hi_wr_r    <= hi_wr_nxt;
			hi_wdata_r <= hi_wdata_nxt;
			tclk_cfg_r <= tclk_cfg_nxt;
			pad_drv_r  <= pad_drv_nxt;
			gpio_dir_r <= gpio_dir_nxt;
			gpio_oe_r  <= gpio_oe_nxt;
			test_clk_r <= test_clk_nxt;
			test_oe_r  <= test_oe_nxt;
			tmr_sel_r  <= tmr_sel_nxt;
			tmr_clk_r  <= tmr_clk_nxt;
			tmr_tick_r <= tmr_tick_nxt;
		end
	end

	assign ack_out                      = ack_r;
	assign rdata_out                    = rdata_r;
	assign busy_out                     = busy_r;
	assign hi_dir_wr_out                = hi_wr_r;
	assign hi_dir_wdata_out             = hi_wdata_r;
	assign test_clock_out               = test_clk_r;
	assign test_clock_oe_out            = test_oe_r;
	assign timer_pin_clock_sel_out      = tmr_sel_r;
	assign timer_pin_clock_out          = tmr_clk_r;
	assign timer_pin_tick_out           = tmr_tick_r;
	// field split of the pad strength register
	assign chip_select_pad_strength_out = pad_drv_r[CS_DRV_LSB +: DRV_W];       // [RULE10]
	assign command_pad_strength_out     = pad_drv_r[CMD_DRV_LSB +: DRV_W];      // [RULE10]
	assign byte_mask_pad_strength_out   = pad_drv_r[MASK_DRV_LSB +: DRV_W];     // [RULE10]
	assign address_pad_strength_out     = pad_drv_r[ADDR_DRV_LSB +: DRV_W];     // [RULE10]
	assign data_pad_strength_out        = pad_drv_r[DATA_DRV_LSB +: DRV_W];     // [RULE10]
	assign gpio_direction_bit_out       = gpio_dir_r;
	assign gpio_oe_out                  = gpio_oe_r;

endmodule // pin_config_clock_test_pad_drive

/* pin_cfg_assertions.sv */
`timescale 1ns/1ps
module pin_cfg_assertions import pin_cfg_pkg::*; (
	// clock, resets and access port
	input  wire logic              clk_sys_in,
	input  wire logic              rst_b_in,
	input  wire logic              soft_reset_in,
	input  wire logic              req_in,
	input  wire logic              wr_in,
	input  wire logic [1:0]        size_in,
	input  wire logic [11:0]       addr_in,
	input  wire logic [31:0]       wdata_in,
	input  wire logic              ack_out,
	input  wire logic              busy_out,
	input  wire logic              hi_dir_wr_out,
	// pin and timer side
	input  wire logic              external_timer_clock_in,
	input  wire logic              test_clock_out,
	input  wire logic              test_clock_oe_out,
	input  wire logic              timer_pin_clock_sel_out,
	input  wire logic              timer_pin_clock_out,
	input  wire logic              timer_pin_tick_out,
	// pads and gpio
	input  wire logic [DRV_W-1:0]  chip_select_pad_strength_out,
	input  wire logic [DRV_W-1:0]  command_pad_strength_out,
	input  wire logic [DRV_W-1:0]  byte_mask_pad_strength_out,
	input  wire logic [DRV_W-1:0]  address_pad_strength_out,
	input  wire logic [DRV_W-1:0]  data_pad_strength_out,
	input  wire logic [GPIO_W-1:0] gpio_function_select_bit_in,
	input  wire logic [GPIO_W-1:0] gpio_direction_bit_out,
	input  wire logic [GPIO_W-1:0] gpio_oe_out
);
	logic        take;
	logic [15:0] wlo;
	logic [15:0] oe_want;
	logic [9:0]  pads;
	assign take = req_in && !busy_out;
	assign wlo = wdata_in[15:0];
	assign oe_want = gpio_direction_bit_out & ~gpio_function_select_bit_in;
	assign pads = {chip_select_pad_strength_out, command_pad_strength_out, byte_mask_pad_strength_out,
		address_pad_strength_out, data_pad_strength_out};

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	// busy without an answer while the upper half is handled, then the answer in the next cycle
	sequence dword_halves;
		busy_out && !ack_out ##1 !busy_out && ack_out;
	endsequence

	dword_split_a: assert property (take && size_in == SZ_DWORD |=> dword_halves)
		else $error("dword access not split into two halves");
	short_ack_a: assert property (take && size_in != SZ_DWORD |=> ack_out && !busy_out)
		else $error("byte or word access not answered next cycle");
	low_first_a: assert property (take && wr_in && size_in == SZ_DWORD && addr_in == GPIO_LO_DIR_OFS |=>
		gpio_direction_bit_out == $past(wlo) && !hi_dir_wr_out ##1 hi_dir_wr_out)
		else $error("low direction not written before upper half");
	gpio_oe_mask_a: assert property (gpio_oe_out == $past(oe_want))
		else $error("gpio output enable wrong");
	pin_exclusive_a: assert property (!(test_clock_oe_out && timer_pin_clock_sel_out))
		else $error("pin both input and output");
	test_quiet_a: assert property (!test_clock_oe_out |-> !test_clock_out)
		else $error("test clock active while not driven");
	timer_quiet_a: assert property (!timer_pin_clock_sel_out && !$past(timer_pin_clock_sel_out) |-> !timer_pin_clock_out)
		else $error("timer pin clock active while unselected");
	tick_pulse_a: assert property (timer_pin_tick_out |=> !timer_pin_tick_out)
		else $error("tick longer than one cycle");
	sync_follow_a: assert property ((timer_pin_clock_sel_out && $stable(external_timer_clock_in))[*6] |->
		timer_pin_clock_out == external_timer_clock_in)
		else $error("timer clock does not follow pin");
	pad_reset_a: assert property ($rose(rst_b_in) |-> pads == 10'h200)
		else $error("pad strength reset value wrong");
	pad_keep_a: assert property (soft_reset_in && !req_in |=> $stable(pads))
		else $error("pad strength lost on soft reset");
	dir_soft_a: assert property (soft_reset_in |=> gpio_direction_bit_out == GPIO_DIR_RST)
		else $error("direction not cleared by soft reset");
endmodule // pin_cfg_assertions

/* pin_far_side.sv */
`timescale 1ns/1ps
module pin_far_side (
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_b_in,
	// shared timer pin
	input  wire logic        dev_oe_in,
	input  wire logic        dev_pin_in,
	output logic             pin_level_out,
	// upper direction register
	input  wire logic        hi_dir_wr_in,
	input  wire logic [15:0] hi_dir_wdata_in,
	output logic      [15:0] hi_dir_rdata_out
);
	logic        osc_r = 1'b0;
	logic [15:0] hi_dir_r;
	// free running external oscillator, yields while the device drives
	always #40 osc_r = ~osc_r;
	assign pin_level_out = dev_oe_in ? dev_pin_in : osc_r;
	always_ff @(posedge clk_sys_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			hi_dir_r <= 16'h0000;
		else if (hi_dir_wr_in)
			hi_dir_r <= hi_dir_wdata_in;
	end
	assign hi_dir_rdata_out = hi_dir_r;
endmodule // pin_far_side

/* testbench.sv */
`timescale 1ns/1ps
module testbench import pin_cfg_pkg::*;;
	logic              clk_sys_in = 1'b0;
	logic              rst_b_in = 1'b0;
	logic              soft_reset_in = 1'b0;
	logic              req_in = 1'b0;
	logic              wr_in = 1'b0;
	logic [1:0]        size_in = SZ_BYTE;
	logic [11:0]       addr_in = 12'h000;
	logic [31:0]       wdata_in = 32'h0000_0000;
	logic [5:0]        src_clk = 6'h00;
	logic [GPIO_W-1:0] fsel = 16'h0000;
	logic              ack_out, busy_out, hi_wr, test_clock_out, test_clock_oe_out, pin_level;
	logic              pin_sel, pin_clk, pin_tick;
	logic [31:0]       rdata_out;
	logic [15:0]       hi_wd, hi_rd;
	logic [DRV_W-1:0]  cs_drv, cmd_drv, mask_drv, addr_drv, data_drv;
	logic [GPIO_W-1:0] dir_bits, gpio_oe;
	int                n_mismatch = 0;
	int                comparisons = 0;

	always #2 clk_sys_in = ~clk_sys_in;
	always #8 src_clk[0] = ~src_clk[0];
	always #12 src_clk[1] = ~src_clk[1];
	always #20 src_clk[2] = ~src_clk[2];
	always #28 src_clk[3] = ~src_clk[3];
	always #40 src_clk[4] = ~src_clk[4];
	always #60 src_clk[5] = ~src_clk[5];

	pin_config_clock_test_pad_drive dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
		.soft_reset_in(soft_reset_in), .req_in(req_in), .wr_in(wr_in), .size_in(size_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .ack_out(ack_out), .rdata_out(rdata_out), .busy_out(busy_out),
		.hi_dir_wr_out(hi_wr), .hi_dir_wdata_out(hi_wd), .hi_dir_rdata_in(hi_rd),
		.rtc_clock_in(src_clk[0]), .serial_slow_clock_in(src_clk[1]), .serial_fast_clock_in(src_clk[2]),
		.interval_timer_clock_in(src_clk[3]), .first_synth_clock_in(src_clk[4]),
		.second_synth_clock_in(src_clk[5]), .external_timer_clock_in(pin_level),
		.test_clock_out(test_clock_out), .test_clock_oe_out(test_clock_oe_out),
		.timer_pin_clock_sel_out(pin_sel), .timer_pin_clock_out(pin_clk), .timer_pin_tick_out(pin_tick),
		.chip_select_pad_strength_out(cs_drv), .command_pad_strength_out(cmd_drv),
		.byte_mask_pad_strength_out(mask_drv), .address_pad_strength_out(addr_drv),
		.data_pad_strength_out(data_drv), .gpio_function_select_bit_in(fsel),
		.gpio_direction_bit_out(dir_bits), .gpio_oe_out(gpio_oe));

	pin_far_side far (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .dev_oe_in(test_clock_oe_out),
		.dev_pin_in(test_clock_out), .pin_level_out(pin_level), .hi_dir_wr_in(hi_wr),
		.hi_dir_wdata_in(hi_wd), .hi_dir_rdata_out(hi_rd));

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// request dropped after the taking edge, answer awaited under a bound
	task automatic acc(input logic w, input logic [1:0] sz, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		req_in = 1'b1;
		wr_in = w;
		size_in = sz;
		addr_in = a;
		wdata_in = d;
		@(posedge clk_sys_in);
		#1;
		req_in = 1'b0;
		for (n = 0; n < 8 && ack_out !== 1'b1; n++)
		begin
			@(posedge clk_sys_in);
			#1;
		end
		q = rdata_out & (sz == SZ_BYTE ? 32'h0000_00FF : sz == SZ_DWORD ? 32'hFFFF_FFFF : 32'h0000_FFFF);
		@(posedge clk_sys_in);
		#1;
		if (n == 8)
		begin
			n_mismatch++;
			$display("CHECK FAILED ack expected 1 seen timeout");
			final_report();
		end
	endtask

	task automatic wr(input logic [1:0] sz, input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, sz, a, d, q);
	endtask

	task automatic rchk(input string nm, input logic [1:0] sz, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, sz, a, 32'h0000_0000, q);
		chk(nm, e, q);
	endtask

	task automatic pulse_soft;
		soft_reset_in = 1'b1;
		@(posedge clk_sys_in);
		#1;
		soft_reset_in = 1'b0;
		@(posedge clk_sys_in);
		#1;
	endtask

	// rising edges of the test clock, or timer ticks, over 1200 ns
	task automatic count_edges(input logic tick, output int c);
		logic p;
		c = 0;
		p = test_clock_out;
		repeat (300)
		begin
			@(posedge clk_sys_in);
			#1;
			c += tick ? int'(pin_tick === 1'b1) : int'(test_clock_out === 1'b1 && p === 1'b0);
			p = test_clock_out;
		end
	endtask

	task automatic scn_reset;
		rchk("clock cfg", SZ_BYTE, TCLK_CFG_OFS, 32'h0000_0070);
		rchk("pad drive", SZ_WORD, PAD_DRV_OFS, 32'h0000_0200);
		rchk("low dir", SZ_WORD, GPIO_LO_DIR_OFS, 32'h0000_0000);
		rchk("unmapped", SZ_WORD, 12'h000, 32'h0000_0000);
		chk("pin active", 32'h0, 32'({test_clock_oe_out, pin_sel}));
		chk("gpio oe", 32'h0, 32'(gpio_oe));
	endtask

	task automatic scn_pads;
		wr(SZ_WORD, PAD_DRV_OFS, 32'h0000_03FF);
		rchk("pad bits", SZ_WORD, PAD_DRV_OFS, 32'h0000_03FF);
		wr(SZ_WORD, PAD_DRV_OFS, 32'h0000_0166);
		chk("pad fields", 32'h0000_0166, 32'({cs_drv, cmd_drv, mask_drv, addr_drv, data_drv}));
		pulse_soft();
		rchk("pad kept", SZ_WORD, PAD_DRV_OFS, 32'h0000_0166);
	endtask

	task automatic scn_sources;
		int c;
		int tol;
		int exp_rise [8] = '{75, 50, 30, 21, 15, 10, 0, 0};
		for (int s = 0; s < 8; s++)
		begin
			wr(SZ_BYTE, TCLK_CFG_OFS, 32'(s * 16 + 3));
			count_edges(1'b0, c);
			tol = (exp_rise[s] > 0) ? 2 : 0;
			chk("test clk rises", 32'h1, 32'(c >= exp_rise[s] - tol && c <= exp_rise[s] + tol));
			chk("test clk oe", 32'h1, 32'(test_clock_oe_out));
			if (s >= 6)
				chk("pin low", 32'h0, 32'(test_clock_out));
		end
		wr(SZ_BYTE, TCLK_CFG_OFS, 32'h0000_0012);
		count_edges(1'b0, c);
		chk("disabled pin", 32'h0, 32'(c) + 32'(test_clock_oe_out));
	endtask

	task automatic scn_input;
		int c;
		wr(SZ_BYTE, TCLK_CFG_OFS, 32'h0000_0071);
		chk("timer pin sel", 32'h2, 32'({pin_sel, test_clock_oe_out}));
		count_edges(1'b1, c);
		chk("timer ticks", 32'h1, 32'(c >= 13 && c <= 17));
		wr(SZ_BYTE, TCLK_CFG_OFS, 32'h0000_0070);
		count_edges(1'b1, c);
		chk("ticks off", 32'h0, 32'(c) + 32'(pin_clk));
	endtask

	task automatic scn_gpio;
		fsel = 16'h00FF;
		wr(SZ_WORD, GPIO_LO_DIR_OFS, 32'h0000_A5C3);
		chk("dir bits", 32'h0000_A5C3, 32'(dir_bits));
		chk("gpio oe", 32'h0000_A500, 32'(gpio_oe));
		wr(SZ_DWORD, GPIO_LO_DIR_OFS, 32'h1234_5678);
		rchk("dir dword", SZ_DWORD, GPIO_LO_DIR_OFS, 32'h1234_5678);
		chk("upper dir", 32'h0000_1234, 32'(hi_rd));
		wr(SZ_BYTE, GPIO_LO_DIR_OFS + 12'h001, 32'h0000_00FF);
		rchk("dir odd byte", SZ_WORD, GPIO_LO_DIR_OFS, 32'h0000_FF78);
		pulse_soft();
		rchk("dir soft", SZ_WORD, GPIO_LO_DIR_OFS, 32'h0000_0000);
	endtask

	initial
	begin
		repeat (4) @(posedge clk_sys_in);
		#1;
		rst_b_in = 1'b1;
		scn_reset();
		scn_pads();
		scn_sources();
		scn_input();
		scn_gpio();
		final_report();
	end
endmodule // testbench

bind pin_config_clock_test_pad_drive pin_cfg_assertions chk (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
	.soft_reset_in(soft_reset_in), .req_in(req_in), .wr_in(wr_in), .size_in(size_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .ack_out(ack_out), .busy_out(busy_out), .hi_dir_wr_out(hi_dir_wr_out),
	.external_timer_clock_in(external_timer_clock_in), .test_clock_out(test_clock_out),
	.test_clock_oe_out(test_clock_oe_out), .timer_pin_clock_sel_out(timer_pin_clock_sel_out),
	.timer_pin_clock_out(timer_pin_clock_out), .timer_pin_tick_out(timer_pin_tick_out),
	.chip_select_pad_strength_out(chip_select_pad_strength_out), .command_pad_strength_out(command_pad_strength_out),
	.byte_mask_pad_strength_out(byte_mask_pad_strength_out), .address_pad_strength_out(address_pad_strength_out),
	.data_pad_strength_out(data_pad_strength_out), .gpio_function_select_bit_in(gpio_function_select_bit_in),
	.gpio_direction_bit_out(gpio_direction_bit_out), .gpio_oe_out(gpio_oe_out));
